// ---- hw/pcs_pkg.sv ----
// Package with register offsets, widths and reset values for the program counter block
package pcs_pkg;
  localparam int          PC_W          = 13;
  localparam int          LOW_W         = 8;
  localparam int          HI_W          = 5;
  localparam int          JMP_W         = 11;
  localparam int          STACK_DEPTH   = 8;
  localparam int          SP_W          = 3;
  localparam logic [7:0]  OFF_PC_LOW    = 8'h02;
  localparam logic [7:0]  OFF_HI_LATCH  = 8'h0a;
  localparam logic [12:0] PC_RESET      = 13'h0000;
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  localparam logic [2:0]  SP_RESET      = 3'h0;
  localparam logic [7:0]  RD_UNMAPPED   = 8'h00;
  localparam int          PAGE_LSB      = 11;
  localparam int          LATCH_PAGE_LO = 3;
endpackage : pcs_pkg

// ---- hw/pcs_core.sv ----
// Program counter sequencer with paged loading and circular return stack
// Operation
// - 13-bit counter, low byte software read/write
// - Upper five bits unreadable, written via latch
// - Any reset clears upper counter bits
// - Low-byte write loads upper bits from latch
// - Call/jump: 11-bit field plus latch page
// - Eight-entry 13-bit hidden return stack
// - Stack pointer hidden from software
// - Call or interrupt vectoring pushes counter
// - Return variants pop stack into counter
// - Push and pop leave latch unchanged
// - Stack wraps circularly, ninth overwrites first
// - No overflow or underflow flags
// - Return restores full counter, ignores latch
// - 8K word space, 2K word pages
`timescale 1ns/1ps
module pcs_core
  import pcs_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [7:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  input  wire logic             i_fetch,
  input  wire logic             i_call,
  input  wire logic             i_jump,
  input  wire logic [JMP_W-1:0] i_target,
  input  wire logic             i_vector,
  input  wire logic [PC_W-1:0]  i_vector_addr,
  input  wire logic             i_ret,
  output logic      [7:0]       o_rdata,
  output logic      [PC_W-1:0]  o_pc
);

  logic [PC_W-1:0]  pc_r;
  logic [PC_W-1:0]  pc_nxt;
  logic [7:0]       latch_r;
  logic [7:0]       rdata_r;
  logic [SP_W-1:0]  sp_r;
  logic [PC_W-1:0]  stack_r [DEPTH];
  logic             push;
  logic             low_wr;
  logic [PC_W-1:0]  push_val;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign push   = i_call | i_vector;
  assign low_wr = i_wr & hit(i_addr, OFF_PC_LOW);

  // Next counter; priority: vector, return, call/jump, low write, fetch
  always_comb
  begin
    pc_nxt = pc_r;
    if (i_vector)
      pc_nxt = i_vector_addr;
    else if (i_ret)
      pc_nxt = stack_r[sp_r - 3'h1];
    else if (i_call | i_jump)
      pc_nxt = {latch_r[LATCH_PAGE_LO +: 2], i_target};
    else if (low_wr)
      pc_nxt = {latch_r[HI_W-1:0], i_wdata};
    else if (i_fetch)
      pc_nxt = pc_r + 13'h0001;
  end

  // Counter register, cleared on reset
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pc_r <= PC_RESET;
    else
      pc_r <= pc_nxt;
  end

  // High latch, touched only by software writes
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      latch_r <= LATCH_RESET;
    else if (i_wr && hit(i_addr, OFF_HI_LATCH))
      latch_r <= i_wdata;
  end

  // Stack pointer, wraps silently with no flags
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      sp_r <= SP_RESET;
    else if (push)
      sp_r <= sp_r + 3'h1;
    else if (i_ret)
      sp_r <= sp_r - 3'h1;
  end

  // Push value: a call returns past itself, a vector resumes here
  assign push_val = i_vector ? pc_r : pc_r + 13'h0001;

  // One register per stack entry, written when the pointer selects it
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_entry
    always_ff @(posedge i_clk)
    begin
      if (push && (sp_r == SP_W'(g)))
        stack_r[g] <= push_val;
    end

    // A call stores the address after the call instruction
    property p_entry_call;
      @(posedge i_clk) disable iff (i_rst)
      i_call && !i_vector && (sp_r == SP_W'(g))
        |=> stack_r[g] == $past(o_pc) + 13'h0001;
    endproperty : p_entry_call
    a_entry_call: assert property (p_entry_call)
      else $error("call pushed wrong address");

    // A vector stores the counter as it stands
    property p_entry_vector;
      @(posedge i_clk) disable iff (i_rst)
      i_vector && (sp_r == SP_W'(g))
        |=> stack_r[g] == $past(o_pc);
    endproperty : p_entry_vector
    a_entry_vector: assert property (p_entry_vector)
      else $error("vector pushed wrong address");
  end : g_entry

  // Read data one cycle after strobe; upper bits never visible
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_r <= RD_UNMAPPED;
    else if (i_rd && hit(i_addr, OFF_PC_LOW))
      rdata_r <= pc_r[LOW_W-1:0];
    else if (i_rd && hit(i_addr, OFF_HI_LATCH))
      rdata_r <= latch_r;
    else
      rdata_r <= RD_UNMAPPED;
  end

  assign o_rdata = rdata_r;
  assign o_pc    = pc_r;

  a_reset_pc: assert property (@(posedge i_clk) $rose(i_rst) |=> o_pc == PC_RESET)
    else $error("counter not cleared by reset");
  a_low_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (low_wr && !i_vector && !i_ret && !i_call && !i_jump)
      |=> o_pc == {$past(latch_r[4:0]), $past(i_wdata)})
    else $error("low byte write load wrong");
  a_call_page: assert property (@(posedge i_clk) disable iff (i_rst)
    ((i_call || i_jump) && !i_vector && !i_ret)
      |=> o_pc == {$past(latch_r[4:3]), $past(i_target)})
    else $error("call or jump target wrong");
  a_call_ret: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_call && !i_vector && !i_ret) ##1 (i_ret && !i_vector && !i_call)
      |=> o_pc == $past(o_pc, 2) + 13'h0001)
    else $error("return address wrong");
  a_latch_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (push || i_ret) && !i_wr |=> latch_r == $past(latch_r))
    else $error("latch changed by stack op");
  a_sp_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    push && sp_r == 3'h7 |=> sp_r == 3'h0)
    else $error("stack pointer did not wrap");
  a_fetch_inc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_fetch && !i_vector && !i_ret && !i_call && !i_jump && !i_wr
      |=> o_pc == $past(o_pc) + 13'h0001)
    else $error("fetch increment wrong");
  a_read_low: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd && i_addr == OFF_PC_LOW |=> o_rdata == $past(o_pc[7:0]))
    else $error("low byte readback wrong");
  a_pop_full: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ret && !i_vector |=> o_pc == $past(stack_r[sp_r - 3'h1]))
    else $error("pop did not restore counter");

  // Vector loads its own address, whatever else is asked
  property p_vector_load;
    @(posedge i_clk) disable iff (i_rst)
    i_vector |=> o_pc == $past(i_vector_addr);
  endproperty : p_vector_load
  a_vector_load: assert property (p_vector_load)
    else $error("vector address not loaded");

  // Return right after a vector resumes the interrupted counter
  property p_vector_ret;
    @(posedge i_clk) disable iff (i_rst)
    (i_vector && !i_ret) ##1 (i_ret && !i_vector && !i_call) |=> o_pc == $past(o_pc, 2);
  endproperty : p_vector_ret
  a_vector_ret: assert property (p_vector_ret)
    else $error("return after vector wrong");

  // Absolute jump never touches the stack pointer
  property p_jump_stack;
    @(posedge i_clk) disable iff (i_rst)
    i_jump && !i_call && !i_vector && !i_ret |=> sp_r == $past(sp_r);
  endproperty : p_jump_stack
  a_jump_stack: assert property (p_jump_stack)
    else $error("jump moved stack pointer");

  // Push advances the pointer by one, modulo depth
  property p_sp_push;
    @(posedge i_clk) disable iff (i_rst)
    push |=> sp_r == $past(sp_r) + 3'h1;
  endproperty : p_sp_push
  a_sp_push: assert property (p_sp_push)
    else $error("push pointer step wrong");

  // Pop steps the pointer back silently, even when empty
  property p_sp_pop;
    @(posedge i_clk) disable iff (i_rst)
    i_ret && !push |=> sp_r == $past(sp_r) - 3'h1;
  endproperty : p_sp_pop
  a_sp_pop: assert property (p_sp_pop)
    else $error("pop pointer step wrong");

  // Push beside a return: the push owns the pointer
  property p_sp_both;
    @(posedge i_clk) disable iff (i_rst)
    push && i_ret |=> sp_r == $past(sp_r) + 3'h1;
  endproperty : p_sp_both
  a_sp_both: assert property (p_sp_both)
    else $error("push and pop clash wrong");

  // Latch takes the full written byte
  property p_latch_load;
    @(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == OFF_HI_LATCH |=> latch_r == $past(i_wdata);
  endproperty : p_latch_load
  a_latch_load: assert property (p_latch_load)
    else $error("latch write lost");

  // Latch holds unless software writes it
  property p_latch_hold;
    @(posedge i_clk) disable iff (i_rst)
    !(i_wr && i_addr == OFF_HI_LATCH) |=> latch_r == $past(latch_r);
  endproperty : p_latch_hold
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed without write");

  // Latch reads back whole
  property p_read_latch;
    @(posedge i_clk) disable iff (i_rst)
    i_rd && i_addr == OFF_HI_LATCH |=> o_rdata == $past(latch_r);
  endproperty : p_read_latch
  a_read_latch: assert property (p_read_latch)
    else $error("latch readback wrong");

  // Read data stands only in the cycle after the strobe
  property p_read_idle;
    @(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == RD_UNMAPPED;
  endproperty : p_read_idle
  a_read_idle: assert property (p_read_idle)
    else $error("read data outside its cycle");

  // Nothing else, stack pointer included, is readable
  property p_read_unmapped;
    @(posedge i_clk) disable iff (i_rst)
    i_rd && i_addr != OFF_PC_LOW && i_addr != OFF_HI_LATCH |=> o_rdata == RD_UNMAPPED;
  endproperty : p_read_unmapped
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

  // Counter holds while nothing is asked
  property p_hold_pc;
    @(posedge i_clk) disable iff (i_rst)
    !i_vector && !i_ret && !i_call && !i_jump && !low_wr && !i_fetch
      |=> o_pc == $past(o_pc);
  endproperty : p_hold_pc
  a_hold_pc: assert property (p_hold_pc)
    else $error("counter moved while idle");

  // Counter wraps at the top of the 8K space
  property p_pc_wrap;
    @(posedge i_clk) disable iff (i_rst)
    i_fetch && !i_vector && !i_ret && !i_call && !i_jump && !low_wr && o_pc == 13'h1fff
      |=> o_pc == 13'h0000;
  endproperty : p_pc_wrap
  a_pc_wrap: assert property (p_pc_wrap)
    else $error("counter wrap wrong");

  // Branch page comes from the latch page bits
  property p_page_bits;
    @(posedge i_clk) disable iff (i_rst)
    (i_call || i_jump) && !i_vector && !i_ret |=> o_pc[12:11] == $past(latch_r[4:3]);
  endproperty : p_page_bits
  a_page_bits: assert property (p_page_bits)
    else $error("branch page wrong");

  // Low-byte write fills all upper bits from the latch
  property p_low_page;
    @(posedge i_clk) disable iff (i_rst)
    low_wr && !i_vector && !i_ret && !i_call && !i_jump
      |=> o_pc[12:8] == $past(latch_r[4:0]);
  endproperty : p_low_page
  a_low_page: assert property (p_low_page)
    else $error("low write upper bits wrong");

  // Low-byte write leaves the stack alone
  property p_low_nopush;
    @(posedge i_clk) disable iff (i_rst)
    low_wr && !push && !i_ret |=> sp_r == $past(sp_r);
  endproperty : p_low_nopush
  a_low_nopush: assert property (p_low_nopush)
    else $error("low write moved stack");

  // Reset empties the stack pointer
  property p_reset_sp;
    @(posedge i_clk)
    $rose(i_rst) |=> sp_r == SP_RESET;
  endproperty : p_reset_sp
  a_reset_sp: assert property (p_reset_sp)
    else $error("stack pointer not cleared");

  // Reset clears read data
  property p_reset_rdata;
    @(posedge i_clk)
    $rose(i_rst) |=> o_rdata == RD_UNMAPPED;
  endproperty : p_reset_rdata
  a_reset_rdata: assert property (p_reset_rdata)
    else $error("read data not cleared");

  // Reset clears the latch as well
  property p_reset_latch;
    @(posedge i_clk)
    $rose(i_rst) |=> latch_r == LATCH_RESET;
  endproperty : p_reset_latch
  a_reset_latch: assert property (p_reset_latch)
    else $error("latch not cleared");

  // Main scenarios
  c_call_ret: cover property (@(posedge i_clk) disable iff (i_rst) i_call ##[1:5] i_ret);
  c_jump: cover property (@(posedge i_clk) disable iff (i_rst) i_jump);
  c_wrap: cover property (@(posedge i_clk) disable iff (i_rst) push && sp_r == 3'h7);
  c_low_wr: cover property (@(posedge i_clk) disable iff (i_rst) low_wr);
  c_vector: cover property (@(posedge i_clk) disable iff (i_rst) i_vector);

endmodule : pcs_core

// ---- testbench/pcs_decoder_model.sv ----
// Behavioural instruction decoder driving the sequencing port
`timescale 1ns/1ps
module pcs_decoder_model
(
  input  wire logic        i_clk,
  output logic             o_fetch,
  output logic             o_call,
  output logic             o_jump,
  output logic             o_vector,
  output logic             o_ret,
  output logic [12:0]      o_addr
);
  initial {o_fetch, o_call, o_jump, o_vector, o_ret, o_addr} = '0;
  // One-cycle request of kind k, operand inverted once released
  task op(input int k, input logic [12:0] a);
    @(posedge i_clk);
    {o_fetch, o_call, o_jump, o_vector, o_ret} <= 5'h10 >> k;
    o_addr <= a;
    @(posedge i_clk);
    {o_fetch, o_call, o_jump, o_vector, o_ret} <= 5'h00;
    o_addr <= ~a;
  endtask : op
endmodule : pcs_decoder_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the program counter block
`timescale 1ns/1ps
module tb_top
  import pcs_pkg::*;
;
  logic            i_clk, i_rst, i_wr, i_rd, f, c, j, v, r;
  logic [7:0]      i_addr, i_wdata, o_rdata;
  logic [12:0]     o_pc, va;
  int              failures, check_count, cyc;
  pcs_decoder_model dec (.i_clk(i_clk), .o_fetch(f), .o_call(c), .o_jump(j),
    .o_vector(v), .o_ret(r), .o_addr(va));
  pcs_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_fetch(f), .i_call(c), .i_jump(j),
    .i_target(va[10:0]), .i_vector(v), .i_vector_addr(va), .i_ret(r),
    .o_rdata(o_rdata), .o_pc(o_pc));
  task chk(input string n, input logic [12:0] e, input logic [12:0] s);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task pc_is(input logic [12:0] e);
    #1 chk("pc", e, o_pc);
  endtask : pc_is
  task wr(input logic [7:0] a, d);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, e);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", {5'h00, e}, {5'h00, o_rdata});
  endtask : rd
  task rst(input int n);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (n) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : rst
  task tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Clock at 100 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // Hang guard
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial
  begin
    {i_wr, i_rd, i_addr, i_wdata} = '0;
    i_rst = 1'b1;
    {failures, check_count, cyc} = '0;
    rst(20);
    wr(OFF_HI_LATCH, 8'h08);
    wr(OFF_PC_LOW, 8'h10);
    pc_is(13'h0810);
    rd(OFF_PC_LOW, 8'h10);
    rd(OFF_HI_LATCH, 8'h08);
    rd(8'h03, 8'h00);
    wr(OFF_HI_LATCH, 8'h18);
    dec.op(2, 13'h0123);
    pc_is(13'h1923);
    $display("registers and jump done");
    wr(OFF_HI_LATCH, 8'h00);
    dec.op(3, 13'h0004);
    pc_is(13'h0004);
    dec.op(4, 13'h0000);
    pc_is(13'h1923);
    rst(2);
    pc_is(13'h0000);
    $display("vector and reset done");
    wr(OFF_HI_LATCH, 8'h1f);
    wr(OFF_PC_LOW, 8'hff);
    dec.op(0, 13'h0000);
    pc_is(13'h0000);
    wr(OFF_HI_LATCH, 8'h07);
    for (int i = 0; i < 9; i++) dec.op(1, 13'h0010 + 13'(i));
    for (int k = 8; k > 0; k--)
    begin
      dec.op(4, 13'h0000);
      pc_is(13'h0010 + 13'(k));
    end
    dec.op(4, 13'h0000);
    pc_is(13'h0018);
    rd(OFF_HI_LATCH, 8'h07);
    $display("stack done");
    wr(OFF_HI_LATCH, 8'h02);
    wr(OFF_PC_LOW, 8'hfe);
    dec.op(0, 13'h0000);
    dec.op(0, 13'h0000);
    pc_is(13'h0300);
    wr(OFF_PC_LOW, 8'h05);
    pc_is(13'h0205);
    $display("table boundary done");
    tally_and_finish();
  end
endmodule : tb_top
